//--- brsr_pkg.sv
// Constants shared by the raster setup register bank and its pixel gate.
// Assumes a 32-bit register word and a 32-bit pixel lane per write.
package brsr_pkg;
   // Register indices on the register port
   localparam logic [1:0] IDX_ROP_CTRL_PITCH = 2'h0;
   localparam logic [1:0] IDX_WIDTH_HEIGHT   = 2'h1;
   localparam logic [1:0] IDX_PAT_ADDR       = 2'h2;
   localparam logic [31:0] RESET_WORD       = 32'h00000000;
   // raster_op_control_dest_pitch fields
   localparam int SOLID_BIT      = 31;
   localparam int CLIP_BIT       = 30;
   localparam int SRC_TRANSP_BIT = 29;
   localparam int PAT_TRANSP_BIT = 28;
   localparam int BMASK_HI       = 27;
   localparam int BMASK_LO       = 26;
   localparam int DEPTH_HI       = 25;
   localparam int DEPTH_LO       = 24;
   localparam int ROP_HI         = 23;
   localparam int ROP_LO         = 16;
   localparam int PITCH_HI       = 15;
   localparam int PITCH_LO       = 0;
   // dest_width_height fields
   localparam int HEIGHT_HI      = 28;
   localparam int HEIGHT_LO      = 16;
   localparam int WIDTH_HI       = 12;
   localparam int WIDTH_LO       = 0;
   localparam logic [31:0] WH_MASK  = 32'h1FFF1FFF;
   // color_pattern_address: bits 28:6 kept, the rest read zero
   localparam logic [31:0] PAT_MASK = 32'h1FFFFFC0;
   // Color depth codes
   typedef enum logic [1:0] {
      DEPTH_8  = 2'h0,
      DEPTH_16 = 2'h1,
      DEPTH_32 = 2'h2,
      DEPTH_RS = 2'h3
   } brsr_depth_t;
   // Byte lanes at 8 and 16 bpp, 8x8 pattern size at 8 bpp, and mono pattern bytes
   localparam logic [3:0]  BE_8BPP      = 4'h1;
   localparam logic [3:0]  BE_16BPP     = 4'h3;
   localparam logic [9:0]  PAT_BYTES_8  = 10'h040;
   localparam logic [3:0]  MONO_PAT_BYTES = 4'h8;
endpackage

//--- brsr_pixel_gate.sv
// Per-pixel operand selection, raster operation and byte-enable gating.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/1ps
module brsr_pixel_gate (
   // Control fields
   input  wire logic             solid_pat,
   input  wire logic             src_transp,
   input  wire logic             pat_transp,
   input  wire logic [1:0]       byte_mask,
   input  wire logic [1:0]       depth,
   input  wire logic [7:0]       rop,
   // Operand kinds and bits
   input  wire logic             src_mono,
   input  wire logic             pat_mono,
   input  wire logic             src_bit,
   input  wire logic             pat_bit,
   // Colors
   input  wire logic [31:0]      src_color,
   input  wire logic [31:0]      pat_color,
   input  wire logic [31:0]      dst_color,
   input  wire logic [31:0]      src_fg,
   input  wire logic [31:0]      src_bg,
   input  wire logic [31:0]      pat_fg,
   input  wire logic [31:0]      pat_bg,
   // Results
   output logic [31:0]           result,
   output logic [3:0]            byte_en
);
   wire logic        pat_bit_eff;
   wire logic [31:0] pat_op;
   wire logic [31:0] src_op;
   wire logic [3:0]  depth_lanes;
   wire logic        keep_dst;

   // Solid pattern forces every pattern bit to zero
   assign pat_bit_eff = pat_bit & ~solid_pat;
   assign pat_op = (solid_pat | pat_mono) ? (pat_bit_eff ? pat_fg : pat_bg)
                                          : pat_color;
   assign src_op = src_mono ? (src_bit ? src_fg : src_bg) : src_color;

   // Each result bit is the rop bit indexed by {pattern, source, destination}
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_rop
         assign result[i] = rop[{pat_op[i], src_op[i], dst_color[i]}];
      end
   endgenerate

   assign depth_lanes = (depth == brsr_pkg::DEPTH_8)  ? brsr_pkg::BE_8BPP :
                        (depth == brsr_pkg::DEPTH_16) ? brsr_pkg::BE_16BPP :
                        {byte_mask[1], {3{byte_mask[0]}}};
   // Transparent zero bits leave the destination untouched
   assign keep_dst = (src_mono & src_transp & ~src_bit)
                   | (pat_mono & pat_transp & ~pat_bit_eff);
   assign byte_en = keep_dst ? 4'h0 : depth_lanes;
endmodule

//--- blit_raster_setup_regs.sv
// Setup register bank of a 2D block-transfer engine with its per-line and
// per-pixel control. Assumes the engine datapath supplies pixel bits and
// colors and signals the start of each transfer and the end of each scan line.
//
// Overview of operation
// - Solid mono pattern skips pattern memory reads
// - Solid pattern forces pattern operand to background
// - Opaque mono source uses background for zeros
// - Transparent mono source: zero bits not written
// - Transparent mono pattern: zero bits not written
// - 32bpp byte mask gates alpha and color bytes
// - Eight-bit raster op selects boolean combination
// - Signed pitch added to address per line
// - Thirteen-bit height counts down per line
// - Byte width converts to pixels by depth
// - Pattern address bits 28:6, rest zero
// - Color pattern is 8x8 at system depth
// - Mono pattern is 8 bytes from command
`timescale 1ns/1ps
module blit_raster_setup_regs #(
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [1:0]        reg_idx,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [31:0]       reg_wdata,
   output logic [31:0]            reg_rdata,
   // Line control from the engine
   input  wire logic              blt_start,
   input  wire logic [ADDR_W-1:0] dest_base,
   input  wire logic              line_done,
   output logic [ADDR_W-1:0]      dest_addr,
   output logic [12:0]            lines_left,
   output logic [12:0]            pixels_per_line,
   // Pattern fetch
   output logic                   pat_fetch_en,
   output logic [9:0]             pat_bytes,
   output logic [ADDR_W-1:0]      pat_base,
   // Pixel inputs
   input  wire logic              pix_valid,
   input  wire logic              src_mono,
   input  wire logic              pat_mono,
   input  wire logic              src_bit,
   input  wire logic [63:0]       mono_pattern,
   input  wire logic [2:0]        pat_x,
   input  wire logic [2:0]        pat_y,
   input  wire logic              clip_inside,
   input  wire logic [31:0]       src_color,
   input  wire logic [31:0]       pat_color,
   input  wire logic [31:0]       dst_color,
   input  wire logic [31:0]       src_fg,
   input  wire logic [31:0]       src_bg,
   input  wire logic [31:0]       pat_fg,
   input  wire logic [31:0]       pat_bg,
   // Pixel write out
   output logic                   wr_valid,
   output logic [31:0]            wr_data,
   output logic [3:0]             wr_byte_en
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0]       ctrl_reg, ctrl_next;
   logic [31:0]       wh_reg, wh_next;
   logic [31:0]       pat_reg, pat_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic [ADDR_W-1:0] daddr_reg, daddr_next;
   logic              wv_reg;
   logic [31:0]       wd_reg;
   logic [3:0]        wbe_reg;

   wire logic              solid_pat  = ctrl_reg[brsr_pkg::SOLID_BIT];
   wire logic              clip_en    = ctrl_reg[brsr_pkg::CLIP_BIT];
   wire logic              src_transp = ctrl_reg[brsr_pkg::SRC_TRANSP_BIT];
   wire logic              pat_transp = ctrl_reg[brsr_pkg::PAT_TRANSP_BIT];
   wire logic [1:0]        byte_mask  = ctrl_reg[brsr_pkg::BMASK_HI:brsr_pkg::BMASK_LO];
   wire logic [1:0]        depth      = ctrl_reg[brsr_pkg::DEPTH_HI:brsr_pkg::DEPTH_LO];
   wire logic [7:0]        rop        = ctrl_reg[brsr_pkg::ROP_HI:brsr_pkg::ROP_LO];
   wire logic [15:0]       pitch      = ctrl_reg[brsr_pkg::PITCH_HI:brsr_pkg::PITCH_LO];
   wire logic [12:0]       height     = wh_reg[brsr_pkg::HEIGHT_HI:brsr_pkg::HEIGHT_LO];
   wire logic [12:0]       width      = wh_reg[brsr_pkg::WIDTH_HI:brsr_pkg::WIDTH_LO];
   wire logic [ADDR_W-1:0] pitch_ext  = ADDR_W'({{(ADDR_W-16){pitch[15]}}, pitch});
   wire logic              wr_ctrl    = reg_wr && (reg_idx == brsr_pkg::IDX_ROP_CTRL_PITCH);
   wire logic              wr_wh      = reg_wr && (reg_idx == brsr_pkg::IDX_WIDTH_HEIGHT);
   wire logic              wr_pat     = reg_wr && (reg_idx == brsr_pkg::IDX_PAT_ADDR);
   wire logic              line_step  = line_done && (height != 13'h0000);
   wire logic [12:0]       height_dec = height - 13'h0001;
   wire logic              pat_bit;
   wire logic [31:0]       gate_result;
   wire logic [3:0]        gate_be;
   wire logic              clip_block = clip_en & ~clip_inside;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; a software write to the size register wins over the
   // engine's own line count update in the same cycle, so a reload is exact.
   assign ctrl_next = wr_ctrl ? reg_wdata : ctrl_reg;
   assign pat_next  = wr_pat ? (reg_wdata & brsr_pkg::PAT_MASK) : pat_reg;
   assign wh_next   = wr_wh ? (reg_wdata & brsr_pkg::WH_MASK) :
                      line_step ? {3'h0, height_dec, 3'h0, width} : wh_reg;
   assign daddr_next = blt_start ? dest_base :
                       line_step ? daddr_reg + pitch_ext : daddr_reg;

   // Read decode, unused index reads zero
   assign rdata_next = !reg_rd ? rdata_reg :
                       (reg_idx == brsr_pkg::IDX_ROP_CTRL_PITCH) ? ctrl_reg :
                       (reg_idx == brsr_pkg::IDX_WIDTH_HEIGHT)   ? wh_reg :
                       (reg_idx == brsr_pkg::IDX_PAT_ADDR)       ? pat_reg :
                       brsr_pkg::RESET_WORD;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_reg  <= brsr_pkg::RESET_WORD;
         wh_reg    <= brsr_pkg::RESET_WORD;
         pat_reg   <= brsr_pkg::RESET_WORD;
         rdata_reg <= brsr_pkg::RESET_WORD;
         daddr_reg <= '0;
      end else begin
         ctrl_reg  <= ctrl_next;
         wh_reg    <= wh_next;
         pat_reg   <= pat_next;
         rdata_reg <= rdata_next;
         daddr_reg <= daddr_next;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign dest_addr  = daddr_reg;
   assign lines_left = height;

   ////////////////////////////////////////////////////////////////////////////
   // Byte width to pixels; the reserved depth code is treated as 32 bpp
   assign pixels_per_line = (depth == brsr_pkg::DEPTH_8)  ? width :
                            (depth == brsr_pkg::DEPTH_16) ? {1'b0, width[12:1]} :
                            {2'h0, width[12:2]};

   // Pattern memory reads are skipped for solid mono patterns; mono
   // patterns never come from memory anyway, they ride in the command.
   assign pat_fetch_en = ~pat_mono & ~(solid_pat & pat_mono);
   assign pat_bytes    = (depth == brsr_pkg::DEPTH_8)  ? brsr_pkg::PAT_BYTES_8 :
                         (depth == brsr_pkg::DEPTH_16) ? {brsr_pkg::PAT_BYTES_8[8:0], 1'b0} :
                         {brsr_pkg::PAT_BYTES_8[7:0], 2'h0};
   assign pat_base     = ADDR_W'(pat_reg);
   assign pat_bit      = mono_pattern[{pat_y, pat_x}];

   brsr_pixel_gate u_gate (
      .solid_pat  (solid_pat),
      .src_transp (src_transp),
      .pat_transp (pat_transp),
      .byte_mask  (byte_mask),
      .depth      (depth),
      .rop        (rop),
      .src_mono   (src_mono),
      .pat_mono   (pat_mono),
      .src_bit    (src_bit),
      .pat_bit    (pat_bit),
      .src_color  (src_color),
      .pat_color  (pat_color),
      .dst_color  (dst_color),
      .src_fg     (src_fg),
      .src_bg     (src_bg),
      .pat_fg     (pat_fg),
      .pat_bg     (pat_bg),
      .result     (gate_result),
      .byte_en    (gate_be)
   );

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wv_reg  <= 1'b0;
         wd_reg  <= brsr_pkg::RESET_WORD;
         wbe_reg <= 4'h0;
      end else begin
         wv_reg  <= pix_valid;
         wd_reg  <= gate_result;
         wbe_reg <= clip_block ? 4'h0 : gate_be;
      end
   end

   assign wr_valid   = wv_reg;
   assign wr_data    = wd_reg;
   assign wr_byte_en = wbe_reg;

   ////////////////////////////////////////////////////////////////////////////
   property p_solid_no_fetch;
      @(posedge clock) disable iff (sys_rst)
      (solid_pat && pat_mono) |-> !pat_fetch_en;
   endproperty
   a_solid_no_fetch: assert property (p_solid_no_fetch)
      else $error("pattern fetch enabled for solid mono pattern");

   property p_solid_bg;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && solid_pat && (rop == 8'hF0) && !clip_block)
         |=> (wr_data == $past(pat_bg));
   endproperty
   a_solid_bg: assert property (p_solid_bg)
      else $error("solid pattern did not use background color");

   property p_src_opaque;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && src_mono && !src_transp && !src_bit && rop == 8'hCC)
         |=> (wr_data == $past(src_bg));
   endproperty
   a_src_opaque: assert property (p_src_opaque)
      else $error("opaque mono source zero did not use background");

   property p_src_transp;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && src_mono && src_transp && !src_bit) |=> (wr_byte_en == 4'h0);
   endproperty
   a_src_transp: assert property (p_src_transp)
      else $error("transparent source zero bit was written");

   property p_pat_transp;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && pat_mono && pat_transp && !pat_bit) |=> (wr_byte_en == 4'h0);
   endproperty
   a_pat_transp: assert property (p_pat_transp)
      else $error("transparent pattern zero bit was written");

   property p_alpha_mask;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && depth == brsr_pkg::DEPTH_32 && !clip_block
       && !(src_mono && src_transp) && !(pat_mono && pat_transp))
         |=> (wr_byte_en == {$past(byte_mask[1]), {3{$past(byte_mask[0])}}});
   endproperty
   a_alpha_mask: assert property (p_alpha_mask)
      else $error("32 bpp byte mask not applied");

   sequence s_line_seen;
      line_step && !wr_wh && !blt_start;
   endsequence
   property p_pitch_step;
      @(posedge clock) disable iff (sys_rst)
      s_line_seen |=> (dest_addr == $past(dest_addr) + $past(pitch_ext))
                      && (lines_left == $past(lines_left) - 13'h0001);
   endproperty
   a_pitch_step: assert property (p_pitch_step)
      else $error("line completion did not advance address and count");

   property p_pat_reserved;
      @(posedge clock) disable iff (sys_rst)
      (reg_rd && (reg_idx == brsr_pkg::IDX_PAT_ADDR))
         |=> ((reg_rdata & ~brsr_pkg::PAT_MASK) == 32'h00000000);
   endproperty
   a_pat_reserved: assert property (p_pat_reserved)
      else $error("pattern address reserved bits not zero");

   property p_clip;
      @(posedge clock) disable iff (sys_rst)
      (pix_valid && clip_en && !clip_inside) |=> (wr_byte_en == 4'h0);
   endproperty
   a_clip: assert property (p_clip)
      else $error("write outside clip rectangle");
endmodule

//--- blit_raster_setup_regs_tb.sv
// Self-checking testbench for the raster setup register bank.
// Assumes the register port, line control and pixel path timing of the bank.
`timescale 1ns/1ps
module blit_raster_setup_regs_tb;
   localparam logic [31:0] SC = 32'h1111_1111, PC = 32'h2222_2222, DC = 32'h4444_4444;
   localparam logic [31:0] SFG = 32'h0F0F_0F0F, SBG = 32'hF0F0_F0F0;
   localparam logic [31:0] PFG = 32'h00FF_00FF, PBG = 32'hFF00_FF00;
   logic        clock = 1'b0, sys_rst = 1'b1;
   logic [1:0]  reg_idx = 2'h0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, blt_start = 1'b0, line_done = 1'b0;
   logic [31:0] reg_wdata = 32'h0, dest_base = 32'h0, reg_rdata, dest_addr, pat_base, wr_data;
   logic [12:0] lines_left, pixels_per_line;
   logic [9:0]  pat_bytes;
   logic        pat_fetch_en, wr_valid, pix_valid = 1'b0, src_mono = 1'b0, pat_mono = 1'b0;
   logic        src_bit = 1'b0, clip_inside = 1'b1;
   logic [2:0]  pat_x = 3'h0, pat_y = 3'h0;
   logic [3:0]  wr_byte_en;
   logic [31:0] rd;
   int          n_mismatch = 0, checks_done = 0, cyc = 0;
   logic [7:0]  rops [8] = '{8'h00, 8'hFF, 8'hAA, 8'hCC, 8'hF0, 8'h66, 8'h88, 8'hEE};

   blit_raster_setup_regs blit_raster_setup_regs_i (
      .clock(clock), .sys_rst(sys_rst), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .blt_start(blt_start),
      .dest_base(dest_base), .line_done(line_done), .dest_addr(dest_addr),
      .lines_left(lines_left), .pixels_per_line(pixels_per_line), .pat_fetch_en(pat_fetch_en),
      .pat_bytes(pat_bytes), .pat_base(pat_base), .pix_valid(pix_valid), .src_mono(src_mono),
      .pat_mono(pat_mono), .src_bit(src_bit), .mono_pattern(64'h0000_0000_0000_0001),
      .pat_x(pat_x), .pat_y(pat_y), .clip_inside(clip_inside), .src_color(SC), .pat_color(PC),
      .dst_color(DC), .src_fg(SFG), .src_bg(SBG), .pat_fg(PFG), .pat_bg(PBG),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_byte_en(wr_byte_en));

   always #25 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Ceiling well above the roughly 120 cycles the scenarios need
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         summarize();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // All drivers enter and leave one nanosecond after a rising edge; an idle
   // edge follows each strobe so back to back calls never retoggle it at once
   task automatic wreg(input logic [1:0] idx, input logic [31:0] d);
      reg_idx = idx;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock); #1;
      reg_wr = 1'b0;
      @(posedge clock); #1;
   endtask

   task automatic rreg(input logic [1:0] idx, output logic [31:0] d);
      reg_idx = idx;
      reg_rd = 1'b1;
      @(posedge clock); #1;
      reg_rd = 1'b0;
      d = reg_rdata;
      @(posedge clock); #1;
   endtask

   function automatic logic [31:0] mk(input logic sol, clp, st, pt,
                                      input logic [1:0] bm, dp, input logic [7:0] rp);
      mk = {sol, clp, st, pt, bm, dp, rp, 16'h0000};
   endfunction

   // Truth-table lookup indexed by pattern, source and destination bits
   function automatic logic [31:0] re(input logic [7:0] r, input logic [31:0] p, s, d);
      for (int i = 0; i < 32; i++) re[i] = r[{p[i], s[i], d[i]}];
   endfunction

   task automatic pix(input logic [31:0] ctl, input logic sm, pm, sb, ci,
                      input logic [2:0] px, input logic [31:0] ed, input logic [3:0] eb);
      wreg(2'h0, ctl);
      src_mono = sm;
      pat_mono = pm;
      src_bit = sb;
      clip_inside = ci;
      pat_x = px;
      pix_valid = 1'b1;
      @(posedge clock); #1;
      pix_valid = 1'b0;
      check({31'h0, wr_valid}, 32'h1);
      if (eb !== 4'h0) check(wr_data, ed);
      check({28'h0, wr_byte_en}, {28'h0, eb});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         rreg(i[1:0], rd);
         check(rd, 32'h0);
      end
      for (int i = 0; i < 4; i++) wreg(i[1:0], 32'hFFFF_FFFF);
      rreg(2'h0, rd);
      check(rd, 32'hFFFF_FFFF);
      rreg(2'h1, rd);
      check(rd, 32'h1FFF_1FFF);
      check({19'h0, lines_left}, 32'h1FFF);
      rreg(2'h2, rd);
      check(rd, 32'h1FFF_FFC0);
      check(pat_base, 32'h1FFF_FFC0);
      wreg(2'h2, 32'h0000_1F00);
      check(pat_base, 32'h0000_1F00);
      rreg(2'h3, rd);
      check(rd, 32'h0);
   endtask

   task automatic t_lines;
      wreg(2'h0, 32'h0000_FFF0);
      wreg(2'h1, 32'h0003_0040);
      dest_base = 32'h0000_1000;
      blt_start = 1'b1;
      @(posedge clock); #1;
      blt_start = 1'b0;
      check(dest_addr, 32'h0000_1000);
      check({19'h0, lines_left}, 32'h3);
      // Fourth line end arrives with no lines left and must be ignored
      line_done = 1'b1;
      for (int i = 1; i < 5; i++) begin
         @(posedge clock); #1;
         check(dest_addr, 32'h1000 - 32'(16 * (i > 3 ? 3 : i)));
         check({19'h0, lines_left}, 32'(3 - (i > 3 ? 3 : i)));
      end
      line_done = 1'b0;
      for (int d = 0; d < 4; d++) begin
         wreg(2'h0, mk(0, 0, 0, 0, 2'h3, d[1:0], 8'hCC));
         check({19'h0, pixels_per_line}, 32'h40 >> (d == 3 ? 2 : d));
         check({22'h0, pat_bytes}, 32'h40 << (d == 3 ? 2 : d));
      end
   endtask

   task automatic t_pixels;
      foreach (rops[k]) pix(mk(0, 0, 0, 0, 2'h3, 2'h2, rops[k]), rops[k] == 8'hF0, 0, 0, 1,
                            0, re(rops[k], PC, SC, DC), 4'hF);
      pix(mk(0, 0, 0, 0, 2'h3, 2'h2, 8'hCC), 1, 0, 0, 1, 0, SBG, 4'hF);
      pix(mk(0, 0, 1, 0, 2'h3, 2'h2, 8'hCC), 1, 0, 0, 1, 0, SBG, 4'h0);
      pix(mk(0, 0, 1, 0, 2'h3, 2'h2, 8'hCC), 1, 0, 1, 1, 0, SFG, 4'hF);
      pix(mk(0, 0, 0, 0, 2'h3, 2'h2, 8'hF0), 1, 1, 0, 1, 0, PFG, 4'hF);
      check({31'h0, pat_fetch_en}, 32'h0);
      pix(mk(0, 0, 0, 1, 2'h3, 2'h2, 8'hF0), 1, 1, 0, 1, 1, PBG, 4'h0);
      pix(mk(0, 0, 0, 1, 2'h3, 2'h2, 8'hF0), 1, 1, 0, 1, 0, PFG, 4'hF);
      pix(mk(1, 0, 0, 0, 2'h3, 2'h2, 8'hF0), 1, 0, 0, 1, 0, PBG, 4'hF);
      check({31'h0, pat_fetch_en}, 32'h1);
      pix(mk(1, 0, 0, 0, 2'h3, 2'h2, 8'hF0), 1, 1, 0, 1, 0, PBG, 4'hF);
      check({31'h0, pat_fetch_en}, 32'h0);
      pix(mk(0, 0, 0, 0, 2'h0, 2'h2, 8'hCC), 0, 0, 0, 1, 0, SC, 4'h0);
      pix(mk(0, 0, 0, 0, 2'h2, 2'h2, 8'hCC), 0, 0, 0, 1, 0, SC, 4'h8);
      pix(mk(0, 0, 0, 0, 2'h1, 2'h2, 8'hCC), 0, 0, 0, 1, 0, SC, 4'h7);
      pix(mk(0, 0, 0, 0, 2'h0, 2'h0, 8'hCC), 0, 0, 0, 1, 0, SC, 4'h1);
      pix(mk(0, 0, 0, 0, 2'h0, 2'h1, 8'hCC), 0, 0, 0, 1, 0, SC, 4'h3);
      pix(mk(0, 1, 0, 0, 2'h3, 2'h2, 8'hCC), 0, 0, 0, 0, 0, SC, 4'h0);
      pix(mk(0, 1, 0, 0, 2'h3, 2'h2, 8'hCC), 0, 0, 0, 1, 0, SC, 4'hF);
   endtask

   initial begin
      repeat (6) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      t_regs();
      t_lines();
      t_pixels();
      summarize();
   end
endmodule
